//--- e1pm_snapshot_bank.sv
// Per-link E1 performance-monitor counters and their snapshot bank.
// Assumes event pulses come from framer logic on clk; plain register port.
`timescale 1ns/1ps

// Functional notes
// - All snapshot registers are loaded together in one cycle from one set of counts.
// - A write that takes the snapshot request bit from zero to one loads a snapshot.
// - With automatic mode enabled a snapshot is loaded once per second.
// - CRC-4 error count is 10 bits, low byte at 00H, top two bits at 01H.
// - FAS/NFAS error count is 12 bits, low byte at 02H, top four bits at 03H.
// - Alignment change count is 3 bits at 04H.
// - Frame synchronization loss count is 5 bits at 05H.
// - Pattern receiver bit error count is 16 bits, low byte at 06H, high at 07H.
// - Code violation low byte is at 08H; snapshot bits are read-only and reset to zero.
// - Code violations are counted as 16 bits with the high byte at 09H.
module e1pm_snapshot_bank
   import e1pm_pkg::*;
#(
   parameter int SNAP_CYCLES_P = e1pm_pkg::SNAP_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [e1pm_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [e1pm_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [e1pm_pkg::DATA_W-1:0] reg_rdata,
   // Event pulses from the link
   input wire logic crc_error_event,
   input wire logic framing_error_event,
   input wire logic alignment_change_event,
   input wire logic frame_loss_event,
   input wire logic pattern_error_event,
   input wire logic code_violation_event,
   // Interrupt
   output logic irq
);
   import e1pm_pkg::*;

   localparam int TICK_W = $clog2(SNAP_CYCLES_P);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SNAP_CYCLES_P - 1);
   localparam logic [TICK_W-1:0] TICK_ONE = TICK_W'(1);

   typedef struct packed {
      logic [7:0] ctrl;
      logic [IRQ_W-1:0] irq_status;
      logic [IRQ_W-1:0] irq_mask;
      logic [7:0] rdata;
      logic [TICK_W-1:0] tick;
      logic [CRC_W-1:0] crc_snap;
      logic [FER_W-1:0] fer_snap;
      logic [ALIGN_W-1:0] align_snap;
      logic [LOSS_W-1:0] loss_snap;
      logic [PATTERN_ERROR_COUNT_W-1:0] pattern_error_count_snap;
      logic [LCV_W-1:0] lcv_snap;
      logic irq;
   } e1pm_state_type;

   e1pm_state_type s_r;
   e1pm_state_type s_nxt;

   logic [CRC_W-1:0] crc_count;
   logic [FER_W-1:0] fer_count;
   logic [ALIGN_W-1:0] align_count;
   logic [LOSS_W-1:0] loss_count;
   logic [PATTERN_ERROR_COUNT_W-1:0] pattern_error_count_count;
   logic [LCV_W-1:0] lcv_count;
   logic [5:0] sat_flags;
   logic req_rise;
   logic tick_due;
   logic take;

   // Passes a byte through unchanged; callers zero-fill the narrow field
   function automatic logic [7:0] pad_byte(input logic [7:0] v);
      pad_byte = v;
   endfunction

   e1pm_sat_counter #(.W(CRC_W)) u_crc (
      .clk(clk), .rst(rst), .event_in(crc_error_event), .restart(take),
      .count(crc_count), .saturated(sat_flags[0])
   );
   e1pm_sat_counter #(.W(FER_W)) u_fer (
      .clk(clk), .rst(rst), .event_in(framing_error_event), .restart(take),
      .count(fer_count), .saturated(sat_flags[1])
   );
   e1pm_sat_counter #(.W(ALIGN_W)) u_align (
      .clk(clk), .rst(rst), .event_in(alignment_change_event), .restart(take),
      .count(align_count), .saturated(sat_flags[2])
   );
   e1pm_sat_counter #(.W(LOSS_W)) u_loss (
      .clk(clk), .rst(rst), .event_in(frame_loss_event), .restart(take),
      .count(loss_count), .saturated(sat_flags[3])
   );
   e1pm_sat_counter #(.W(PATTERN_ERROR_COUNT_W)) u_pattern_error_count (
      .clk(clk), .rst(rst), .event_in(pattern_error_event), .restart(take),
      .count(pattern_error_count_count), .saturated(sat_flags[4])
   );
   // One input serves AMI or HDB3 decoding; the decoder picks the violation kind
   e1pm_sat_counter #(.W(LCV_W)) u_lcv (
      .clk(clk), .rst(rst), .event_in(code_violation_event), .restart(take),
      .count(lcv_count), .saturated(sat_flags[5])
   );

   // Snapshot triggers
   assign req_rise = reg_wr && reg_addr == CTRL_ADDR && reg_wdata[CTRL_REQ_BIT] &&
                     !s_r.ctrl[CTRL_REQ_BIT];
   assign tick_due = s_r.ctrl[CTRL_AUTO_BIT] && s_r.tick == TICK_LAST;
   assign take = req_rise || tick_due;

   always_comb begin
      s_nxt = s_r;
      // Second timer runs only while automatic mode is on
      if (!s_r.ctrl[CTRL_AUTO_BIT] || tick_due) begin
         s_nxt.tick = '0;
      end else begin
         s_nxt.tick = s_r.tick + TICK_ONE;
      end
      if (take) begin
         // Counts before restart form one common snapshot
         s_nxt.crc_snap = crc_count;
         s_nxt.fer_snap = fer_count;
         s_nxt.align_snap = align_count;
         s_nxt.loss_snap = loss_count;
         s_nxt.pattern_error_count_snap = pattern_error_count_count;
         s_nxt.lcv_snap = lcv_count;
      end
      // Register writes; snapshot range is read-only
      if (reg_wr) begin
         if (reg_addr == CTRL_ADDR) begin
            s_nxt.ctrl = {6'h00, reg_wdata[CTRL_REQ_BIT], reg_wdata[CTRL_AUTO_BIT]};
         end else if (reg_addr == IRQ_STATUS_ADDR) begin
            s_nxt.irq_status = s_r.irq_status & ~reg_wdata[IRQ_W-1:0];
         end else if (reg_addr == IRQ_MASK_ADDR) begin
            s_nxt.irq_mask = reg_wdata[IRQ_W-1:0];
         end
      end
      // Set wins over a same-cycle clear
      if (take) begin
         s_nxt.irq_status[IRQ_SNAP_BIT] = 1'b1;
      end
      if (|sat_flags) begin
         s_nxt.irq_status[IRQ_SAT_BIT] = 1'b1;
      end
      // Registered so the pin cannot glitch while status bits change
      s_nxt.irq = |(s_nxt.irq_status & s_nxt.irq_mask);
      // Read data stand for one cycle only; reads change nothing else
      s_nxt.rdata = RDATA_IDLE;
      if (reg_rd) begin
         if (reg_addr == CRC_LOW_ADDR) begin
            s_nxt.rdata = s_r.crc_snap[7:0];
         end else if (reg_addr == CRC_HIGH_ADDR) begin
            s_nxt.rdata = pad_byte({6'h00, s_r.crc_snap[9:8]});
         end else if (reg_addr == FER_LOW_ADDR) begin
            s_nxt.rdata = s_r.fer_snap[7:0];
         end else if (reg_addr == FER_HIGH_ADDR) begin
            s_nxt.rdata = pad_byte({4'h0, s_r.fer_snap[11:8]});
         end else if (reg_addr == ALIGN_ADDR) begin
            s_nxt.rdata = pad_byte({5'h00, s_r.align_snap});
         end else if (reg_addr == LOSS_ADDR) begin
            s_nxt.rdata = pad_byte({3'h0, s_r.loss_snap});
         end else if (reg_addr == PATTERN_ERROR_COUNT_LOW_ADDR) begin
            s_nxt.rdata = s_r.pattern_error_count_snap[7:0];
         end else if (reg_addr == PATTERN_ERROR_COUNT_HIGH_ADDR) begin
            s_nxt.rdata = s_r.pattern_error_count_snap[15:8];
         end else if (reg_addr == LCV_LOW_ADDR) begin
            s_nxt.rdata = s_r.lcv_snap[7:0];
         end else if (reg_addr == LCV_HIGH_ADDR) begin
            s_nxt.rdata = s_r.lcv_snap[15:8];
         end else if (reg_addr == CTRL_ADDR) begin
            s_nxt.rdata = s_r.ctrl;
         end else if (reg_addr == IRQ_STATUS_ADDR) begin
            s_nxt.rdata = pad_byte({6'h00, s_r.irq_status});
         end else if (reg_addr == IRQ_MASK_ADDR) begin
            s_nxt.rdata = pad_byte({6'h00, s_r.irq_mask});
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata = s_r.rdata;
   assign irq = s_r.irq;

   a_group_snapshot: assert property (@(posedge clk) disable iff (rst)
      take |=> s_r.crc_snap == $past(crc_count) && s_r.fer_snap == $past(fer_count) &&
               s_r.align_snap == $past(align_count) && s_r.loss_snap == $past(loss_count) &&
               s_r.pattern_error_count_snap == $past(pattern_error_count_count) && s_r.lcv_snap == $past(lcv_count))
      else $error("snapshot group not loaded together");

   a_request_edge: assert property (@(posedge clk) disable iff (rst)
      (reg_wr && reg_addr == CTRL_ADDR && reg_wdata[CTRL_REQ_BIT] && !s_r.ctrl[CTRL_REQ_BIT])
      |=> s_r.irq_status[IRQ_SNAP_BIT] && s_r.lcv_snap == $past(lcv_count))
      else $error("request edge did not snapshot");

   a_auto_period: assert property (@(posedge clk) disable iff (rst)
      (s_r.ctrl[CTRL_AUTO_BIT] && s_r.tick == '0 && $past(tick_due)) ##0
      (s_r.ctrl[CTRL_AUTO_BIT] && !reg_wr) [*2] |-> !take)
      else $error("automatic snapshot came early");

   a_auto_fires: assert property (@(posedge clk) disable iff (rst)
      (s_r.ctrl[CTRL_AUTO_BIT] && s_r.tick == TICK_LAST) |=>
      s_r.irq_status[IRQ_SNAP_BIT] && s_r.tick == '0 && s_r.crc_snap == $past(crc_count))
      else $error("automatic snapshot missed");

   a_crc_high_read: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == CRC_HIGH_ADDR) |=>
      reg_rdata == {6'h00, $past(s_r.crc_snap[9:8])})
      else $error("crc high byte wrong");

   a_fer_high_read: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == FER_HIGH_ADDR) |=>
      reg_rdata == {4'h0, $past(s_r.fer_snap[11:8])})
      else $error("framing high byte wrong");

   a_align_read: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == ALIGN_ADDR) |=> reg_rdata[7:3] == 5'h00 &&
      reg_rdata[2:0] == $past(s_r.align_snap))
      else $error("alignment count read wrong");

   a_loss_read: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == LOSS_ADDR) |=> reg_rdata == {3'h0, $past(s_r.loss_snap)})
      else $error("loss count read wrong");

   a_pattern_error_count_read: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == PATTERN_ERROR_COUNT_HIGH_ADDR) ##1 (reg_rd && reg_addr == PATTERN_ERROR_COUNT_LOW_ADDR && !take)
      |=> reg_rdata == s_r.pattern_error_count_snap[7:0])
      else $error("pattern count read wrong");

   a_snap_readonly: assert property (@(posedge clk) disable iff (rst)
      !take |=> $stable(s_r.crc_snap) && $stable(s_r.lcv_snap) && $stable(s_r.fer_snap))
      else $error("snapshot changed without trigger");

   a_lcv_high_read: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == LCV_HIGH_ADDR) |=> reg_rdata == $past(s_r.lcv_snap[15:8]))
      else $error("code violation high byte wrong");

   a_restart_counts: assert property (@(posedge clk) disable iff (rst)
      take |=> crc_count == {{(CRC_W-1){1'b0}}, $past(crc_error_event)})
      else $error("live counter not restarted");

   a_read_no_effect: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && !reg_wr && !take) |=> $stable(s_r.ctrl) && $stable(s_r.pattern_error_count_snap))
      else $error("read had a side effect");

   // Read path
   a_crc_low_read: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == CRC_LOW_ADDR) |=> reg_rdata == $past(s_r.crc_snap[7:0]))
      else $error("crc low byte wrong");

   a_fer_low_read: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == FER_LOW_ADDR) |=> reg_rdata == $past(s_r.fer_snap[7:0]))
      else $error("framing low byte wrong");

   a_pattern_error_count_high_read: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == PATTERN_ERROR_COUNT_HIGH_ADDR) |=> reg_rdata == $past(s_r.pattern_error_count_snap[15:8]))
      else $error("pattern high byte wrong");

   a_lcv_low_read: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == LCV_LOW_ADDR) |=> reg_rdata == $past(s_r.lcv_snap[7:0]))
      else $error("code violation low byte wrong");

   a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
      !reg_rd |=> reg_rdata == RDATA_IDLE)
      else $error("read data did not return to idle");

   a_unmapped_read: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr > IRQ_MASK_ADDR) |=> reg_rdata == RDATA_IDLE)
      else $error("unmapped read not zero");

   a_ctrl_read: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == CTRL_ADDR) |=> reg_rdata == $past(s_r.ctrl))
      else $error("control read wrong");

   // Control and timer
   a_ctrl_write: assert property (@(posedge clk) disable iff (rst)
      (reg_wr && reg_addr == CTRL_ADDR) |=> s_r.ctrl ==
      {6'h00, $past(reg_wdata[CTRL_REQ_BIT]), $past(reg_wdata[CTRL_AUTO_BIT])})
      else $error("control write wrong");

   a_repeat_request: assert property (@(posedge clk) disable iff (rst)
      (reg_wr && reg_addr == CTRL_ADDR && s_r.ctrl[CTRL_REQ_BIT] && !tick_due) |=>
      $stable(s_r.crc_snap) && $stable(s_r.fer_snap) && $stable(s_r.pattern_error_count_snap))
      else $error("repeated request took a snapshot");

   a_no_auto_when_off: assert property (@(posedge clk) disable iff (rst)
      (!s_r.ctrl[CTRL_AUTO_BIT] && !(reg_wr && reg_addr == CTRL_ADDR)) |=>
      $stable(s_r.lcv_snap) && $stable(s_r.align_snap) && $stable(s_r.loss_snap))
      else $error("snapshot while automatic mode off");

   a_tick_idle: assert property (@(posedge clk) disable iff (rst)
      !s_r.ctrl[CTRL_AUTO_BIT] |=> s_r.tick == '0)
      else $error("timer ran while disabled");

   a_tick_step: assert property (@(posedge clk) disable iff (rst)
      (s_r.ctrl[CTRL_AUTO_BIT] && !tick_due) |=> s_r.tick == $past(s_r.tick) + TICK_ONE)
      else $error("timer skipped a count");

   // Interrupt, then snapshot hold and counter restart
   a_snap_flag_set: assert property (@(posedge clk) disable iff (rst)
      take |=> s_r.irq_status[IRQ_SNAP_BIT])
      else $error("snapshot flag not set");

   a_status_clear: assert property (@(posedge clk) disable iff (rst)
      (reg_wr && reg_addr == IRQ_STATUS_ADDR && reg_wdata[IRQ_SNAP_BIT] && !take) |=>
      !s_r.irq_status[IRQ_SNAP_BIT])
      else $error("status bit not cleared");

   a_status_read: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == IRQ_STATUS_ADDR) |=> reg_rdata == {6'h00, $past(s_r.irq_status)})
      else $error("status read wrong");

   a_mask_write: assert property (@(posedge clk) disable iff (rst)
      (reg_wr && reg_addr == IRQ_MASK_ADDR) |=> s_r.irq_mask == $past(reg_wdata[IRQ_W-1:0]))
      else $error("mask write wrong");

   a_sat_status: assert property (@(posedge clk) disable iff (rst)
      (|sat_flags) |=> s_r.irq_status[IRQ_SAT_BIT])
      else $error("saturation flag not set");

   a_irq_level: assert property (@(posedge clk) disable iff (rst)
      irq == |(s_r.irq_status & s_r.irq_mask))
      else $error("interrupt level wrong");

   a_mask_irq: assert property (@(posedge clk) disable iff (rst)
      (s_r.irq_mask == '0) |-> !irq)
      else $error("masked interrupt raised");

   a_snap_rest_stable: assert property (@(posedge clk) disable iff (rst)
      !take |=> $stable(s_r.align_snap) && $stable(s_r.loss_snap) && $stable(s_r.pattern_error_count_snap))
      else $error("snapshot part changed alone");

   a_restart_all: assert property (@(posedge clk) disable iff (rst)
      take |=> fer_count == {{(FER_W-1){1'b0}}, $past(framing_error_event)} &&
      align_count == {{(ALIGN_W-1){1'b0}}, $past(alignment_change_event)} &&
      loss_count == {{(LOSS_W-1){1'b0}}, $past(frame_loss_event)} &&
      pattern_error_count_count == {{(PATTERN_ERROR_COUNT_W-1){1'b0}}, $past(pattern_error_event)} &&
      lcv_count == {{(LCV_W-1){1'b0}}, $past(code_violation_event)})
      else $error("live counters not restarted together");
endmodule

//--- e1pm_pkg.sv
// Constants shared by the E1 performance-monitor snapshot bank.
// Assumes one 100 MHz clock and an 8-bit register port.
package e1pm_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // Snapshot register offsets
   localparam logic [7:0] CRC_LOW_ADDR = 8'h00;
   localparam logic [7:0] CRC_HIGH_ADDR = 8'h01;
   localparam logic [7:0] FER_LOW_ADDR = 8'h02;
   localparam logic [7:0] FER_HIGH_ADDR = 8'h03;
   localparam logic [7:0] ALIGN_ADDR = 8'h04;
   localparam logic [7:0] LOSS_ADDR = 8'h05;
   localparam logic [7:0] PATTERN_ERROR_COUNT_LOW_ADDR = 8'h06;
   localparam logic [7:0] PATTERN_ERROR_COUNT_HIGH_ADDR = 8'h07;
   localparam logic [7:0] LCV_LOW_ADDR = 8'h08;
   localparam logic [7:0] LCV_HIGH_ADDR = 8'h09;

   // Control and interrupt registers
   localparam logic [7:0] CTRL_ADDR = 8'h10;
   localparam logic [7:0] IRQ_STATUS_ADDR = 8'h11;
   localparam logic [7:0] IRQ_MASK_ADDR = 8'h12;

   localparam int CTRL_AUTO_BIT = 0;
   localparam int CTRL_REQ_BIT = 1;
   localparam int IRQ_SNAP_BIT = 0;
   localparam int IRQ_SAT_BIT = 1;
   localparam int IRQ_W = 2;

   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [1:0] IRQ_RESET = 2'h0;
   localparam logic [7:0] RDATA_IDLE = 8'h00;

   // Counter widths
   localparam int CRC_W = 10;
   localparam int FER_W = 12;
   localparam int ALIGN_W = 3;
   localparam int LOSS_W = 5;
   localparam int PATTERN_ERROR_COUNT_W = 16;
   localparam int LCV_W = 16;

   // Automatic snapshot period
   localparam int CLK_PERIOD_NS = 10;
   localparam int SNAP_PERIOD_NS = 1000000000;
   localparam int SNAP_CYCLES = SNAP_PERIOD_NS / CLK_PERIOD_NS;
endpackage

//--- e1pm_sat_counter.sv
// Saturating event counter with a restart that keeps a coincident event.
// Assumes a one-cycle event pulse from logic on the same clock.
`timescale 1ns/1ps
module e1pm_sat_counter #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Event and restart
   input wire logic event_in,
   input wire logic restart,
   // Count
   output logic [W-1:0] count,
   output logic saturated
);
   typedef struct packed {
      logic [W-1:0] count;
   } e1pm_cnt_type;

   localparam logic [W-1:0] FULL = {W{1'b1}};
   localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

   e1pm_cnt_type s_r;
   e1pm_cnt_type s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (restart) begin
         // Event in the restart cycle opens the next interval
         s_nxt.count = event_in ? ONE : '0;
      end else if (event_in && s_r.count != FULL) begin
         s_nxt.count = s_r.count + ONE;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign count = s_r.count;
   assign saturated = (s_r.count == FULL);

   a_restart_keeps_event: assert property (@(posedge clk) disable iff (rst)
      restart |=> count == ($past(event_in) ? ONE : '0)) else $error("restart lost event");

   a_no_wrap: assert property (@(posedge clk) disable iff (rst)
      (saturated && !restart) |=> saturated) else $error("counter wrapped");
endmodule

//--- tb_e1pm_snapshot_bank.sv
// Self-checking bench for the E1 performance-monitor snapshot bank.
// Assumes the package e1pm_pkg and a shortened automatic snapshot period.
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
   $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp); end end
module tb_e1pm_snapshot_bank;
   import e1pm_pkg::*;
   localparam int SNAP = 64;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic irq;
   logic [5:0] ev = 6'h00;
   logic ev_en = 1'b0;
   logic ctrl_req = 1'b0;
   int errors = 0;
   int cmp_count = 0;
   int cnt[6];
   int snap[6];
   logic [7:0] d;

   always #5 clk = ~clk;

   e1pm_snapshot_bank #(.SNAP_CYCLES_P(SNAP)) i_e1pm_snapshot_bank (
      .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .crc_error_event(ev[0]),
      .framing_error_event(ev[1]), .alignment_change_event(ev[2]), .frame_loss_event(ev[3]),
      .pattern_error_event(ev[4]), .code_violation_event(ev[5]), .irq(irq));

   function automatic int mx(int i);
      int w[6] = '{CRC_W, FER_W, ALIGN_W, LOSS_W, PATTERN_ERROR_COUNT_W, LCV_W};
      return (1 << w[i]) - 1;
   endfunction

   function automatic logic [7:0] exp_byte(int a);
      int idx[10] = '{0, 0, 1, 1, 2, 3, 4, 4, 5, 5};
      int hi[10] = '{0, 1, 0, 1, 0, 0, 0, 1, 0, 1};
      return 8'((snap[idx[a]] >> (8 * hi[a])) & 255);
   endfunction

   function automatic logic sat_any();
      logic s = 1'b0;
      for (int i = 0; i < 6; i++) s |= (cnt[i] == mx(i));
      return s;
   endfunction

   // Reference counts: a snapshot takes the count before this edge's events
   always @(posedge clk) begin
      if (rst) begin
         cnt = '{default: 0};
         snap = '{default: 0};
         ctrl_req = 1'b0;
      end else begin
         if (reg_wr && reg_addr == CTRL_ADDR) begin
            if (reg_wdata[CTRL_REQ_BIT] && !ctrl_req) begin
               snap = cnt;
               cnt = '{default: 0};
            end
            ctrl_req = reg_wdata[CTRL_REQ_BIT];
         end
         for (int i = 0; i < 6; i++) if (ev[i] && cnt[i] != mx(i)) cnt[i]++;
      end
      ev <= ev_en ? 6'($urandom & $urandom) : 6'h00;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
      @(posedge clk);
   endtask

   task automatic check_all();
      logic [7:0] v;
      for (int a = 0; a < 10; a++) begin
         rd(8'(a), v);
         `CHK(v, exp_byte(a), "snapshot byte")
      end
   endtask

   task automatic auto_fire();
      snap = cnt;
      cnt = '{default: 0};
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      #200000;
      errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      print_verdict();
   end

   initial begin
      void'($urandom(32'h0F28));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      // Reset values and unmapped read
      check_all();
      for (int a = 16; a < 19; a++) begin
         rd(8'(a), d);
         `CHK(d, 8'h00, "control reset")
      end
      rd(8'h20, d);
      `CHK(d, RDATA_IDLE, "unmapped read")
      `CHK(irq, 1'b0, "irq after reset")
      $display("test reset done");
      // Manual snapshots over random intervals, one long enough to saturate
      ev_en <= 1'b1;
      for (int k = 0; k < 5; k++) begin
         repeat (k == 2 ? 4500 : 5 + $urandom % 60) @(posedge clk);
         wr(8'($urandom % 10), 8'($urandom));
         wr(CTRL_ADDR, 8'h00);
         wr(CTRL_ADDR, 8'h02);
         check_all();
         wr(CTRL_ADDR, 8'h02);
         check_all();
      end
      wr(CTRL_ADDR, 8'hFC);
      rd(CTRL_ADDR, d);
      `CHK(d, 8'h00, "control spare bits")
      // Back-to-back reads, then the idle value
      reg_addr <= PATTERN_ERROR_COUNT_HIGH_ADDR;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_addr <= PATTERN_ERROR_COUNT_LOW_ADDR;
      #1 `CHK(reg_rdata, exp_byte(7), "back-to-back high")
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 `CHK(reg_rdata, exp_byte(6), "back-to-back low")
      @(posedge clk);
      #1 `CHK(reg_rdata, RDATA_IDLE, "read data idle")
      @(posedge clk);
      $display("test manual done");
      // Interrupt status, mask and clear
      repeat (200) @(posedge clk);
      ev_en <= 1'b0;
      repeat (2) @(posedge clk);
      wr(IRQ_MASK_ADDR, 8'h00);
      wr(IRQ_STATUS_ADDR, 8'h03);
      rd(IRQ_STATUS_ADDR, d);
      `CHK(d, {6'h00, sat_any(), 1'b0}, "saturation status")
      `CHK(irq, 1'b0, "masked irq")
      wr(IRQ_MASK_ADDR, 8'h02);
      `CHK(irq, sat_any(), "saturation irq")
      wr(CTRL_ADDR, 8'h00);
      wr(CTRL_ADDR, 8'h02);
      wr(IRQ_STATUS_ADDR, 8'h02);
      wr(IRQ_MASK_ADDR, 8'h01);
      `CHK(irq, 1'b1, "snapshot irq")
      wr(IRQ_STATUS_ADDR, 8'h01);
      `CHK(irq, 1'b0, "irq cleared")
      rd(IRQ_STATUS_ADDR, d);
      `CHK(d, 8'h00, "status cleared")
      $display("test irq done");
      // Automatic snapshots at the shortened period
      ev_en <= 1'b1;
      repeat (30) @(posedge clk);
      ev_en <= 1'b0;
      repeat (2) @(posedge clk);
      wr(CTRL_ADDR, 8'h01);
      // Clear lands on the firing edge; the set must win
      repeat (SNAP - 2) @(posedge clk);
      wr(IRQ_STATUS_ADDR, 8'h01);
      auto_fire();
      rd(IRQ_STATUS_ADDR, d);
      `CHK(d[IRQ_SNAP_BIT], 1'b1, "first auto snapshot")
      check_all();
      wr(IRQ_STATUS_ADDR, 8'h01);
      rd(IRQ_STATUS_ADDR, d);
      `CHK(d[IRQ_SNAP_BIT], 1'b0, "no early auto snapshot")
      repeat (40) @(posedge clk);
      auto_fire();
      rd(IRQ_STATUS_ADDR, d);
      `CHK(d[IRQ_SNAP_BIT], 1'b1, "second auto snapshot")
      check_all();
      wr(CTRL_ADDR, 8'h00);
      wr(IRQ_STATUS_ADDR, 8'h01);
      repeat (2 * SNAP) @(posedge clk);
      rd(IRQ_STATUS_ADDR, d);
      `CHK(d[IRQ_SNAP_BIT], 1'b0, "auto disabled")
      $display("test auto done");
      // Reset in mid-run, with live counts and a loaded snapshot
      ev_en <= 1'b1;
      repeat (50) @(posedge clk);
      wr(CTRL_ADDR, 8'h02);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      check_all();
      rd(CTRL_ADDR, d);
      `CHK(d, CTRL_RESET, "control after reset")
      `CHK(irq, 1'b0, "irq after second reset")
      ev_en <= 1'b0;
      $display("test reset again done");
      print_verdict();
   end
endmodule
